// ==== bench/test_mcu_bcd_incdec_halt_exec.sv ====
`timescale 1ns/1ns
`default_nettype none
module test_mcu_bcd_incdec_halt_exec;
  // ----------------------------------------
  // Design connections
  // ----------------------------------------
  logic clk;
  logic rst_b;
  bcdx_pkg::bcdx_instr_s instr;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, accumulator;
  logic reg_wr, reg_rd, halted, sys_clk_gate, watchdog_counter_clr, exec_done;
  bcdx_pkg::bcdx_flags_s flags;
  // ----------------------------------------
  // Reference state of the bench
  // ----------------------------------------
  logic [7:0] mem [16]; // Expected data memory
  logic [7:0] acc; // Expected accumulator
  bcdx_pkg::bcdx_flags_s fl; // Expected flags
  logic mh, exp_clr, exp_done, p_wr, p_rd; // Halt, pulses, pending strobes
  bcdx_pkg::bcdx_instr_s p_ins; // Instruction driven last
  logic [7:0] p_addr, p_wd, exp_rd, r_a;
  logic [31:0] r;
  integer seed = 53307;
  int failures = 0;
  int num_checks = 0;
  logic [9:0] adj_tab [8] = '{10'h000, 10'h028, 10'h280, 10'h266, 10'h049, 10'h3FC, 10'h268,
                              10'h117};

  bcdx_core i_bcdx_core (.clk(clk), .rst_b(rst_b), .instr(instr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .accumulator(accumulator), .flags(flags), .halted(halted), .sys_clk_gate(sys_clk_gate),
    .watchdog_counter_clr(watchdog_counter_clr), .exec_done(exec_done));

  // Free running system clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Decimal adjust sum with carry in bit 8
  function automatic logic [8:0] bcd_fix(input logic [7:0] a, input logic c, input logic h);
    logic [7:0] adj;
    adj = bcdx_pkg::ADJ_NONE;
    if (a[3:0] > bcdx_pkg::DIGIT_MAX || h) adj = adj | bcdx_pkg::ADJ_LO;
    if (a[7:4] > bcdx_pkg::DIGIT_MAX || c) adj = adj | bcdx_pkg::ADJ_HI;
    bcd_fix = {1'b0, a} + {1'b0, adj};
    bcd_fix[8] = bcd_fix[8] | c | (a[7:4] > bcdx_pkg::DIGIT_MAX);
  endfunction

  // Expected read data of one offset
  function automatic logic [7:0] rd_val(input logic [7:0] a);
    if (a < 8'h10) return mem[a[3:0]];
    if (a == bcdx_pkg::OFS_ACC) return acc;
    if (a == bcdx_pkg::OFS_STATUS) return {3'h0, fl};
    return 8'h00;
  endfunction

  // One comparison, counted
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Apply what the design took at this edge to the reference
  task automatic take();
    logic [8:0] s;
    logic [3:0] m;
    m = p_ins.addr[3:0];
    exp_done = p_ins.valid && !mh; // Ignored while halted
    exp_clr = 1'b0;
    exp_rd = p_rd ? rd_val(p_addr) : 8'h00;
    if (exp_done) begin
      case (p_ins.op)
        bcdx_pkg::OP_CPL_ACC: acc = ~mem[m];
        bcdx_pkg::OP_BCD_ADJ: begin
          s = bcd_fix(acc, fl.carry_flag, fl.half_carry_flag);
          mem[m] = s[7:0];
          fl.carry_flag = s[8];
        end
        bcdx_pkg::OP_DEC: mem[m] = mem[m] - 8'h01;
        bcdx_pkg::OP_DECR_ACC: acc = mem[m] - 8'h01;
        bcdx_pkg::OP_INC: mem[m] = mem[m] + 8'h01;
        bcdx_pkg::OP_HALT: begin
          fl.powerdown_flag = 1'b1;
          fl.timeout_flag = 1'b0;
          mh = 1'b1;
          exp_clr = 1'b1;
        end
        default: ;
      endcase
      // Zero flag follows the byte written, except by decimal adjust
      if (p_ins.op inside {bcdx_pkg::OP_CPL_ACC, bcdx_pkg::OP_DECR_ACC}) begin
        fl.zero_flag = (acc == 8'h00);
      end
      if (p_ins.op inside {bcdx_pkg::OP_DEC, bcdx_pkg::OP_INC}) fl.zero_flag = (mem[m] == 8'h00);
    end
    if (p_wr) begin
      if (p_addr < 8'h10) mem[p_addr[3:0]] = p_wd;
      else if (p_addr == bcdx_pkg::OFS_ACC) acc = p_wd;
      else if (p_addr == bcdx_pkg::OFS_STATUS) fl = p_wd[4:0];
      else if (p_addr == bcdx_pkg::OFS_CTRL && p_wd[0] && mh) mh = 1'b0; // Wake keeps all flags
    end
  endtask

  // One clock: take pending request, drive next, check at the falling edge
  task automatic step(input logic v, input bcdx_pkg::bcdx_op_e o, input logic [7:0] ia,
                      input logic w, input logic rd, input logic [7:0] ra, input logic [7:0] wd);
    @(posedge clk);
    take();
    instr <= '{v, o, ia};
    reg_wr <= w;
    reg_rd <= rd;
    reg_addr <= ra;
    reg_wdata <= wd;
    p_ins = '{v, o, ia};
    p_wr = w;
    p_rd = rd;
    p_addr = ra;
    p_wd = wd;
    @(negedge clk);
    chk("exec_done", {7'h0, exp_done}, {7'h0, exec_done});
    chk("accumulator", acc, accumulator);
    chk("flags", {3'h0, fl}, {3'h0, flags});
    chk("halted", {6'h0, mh, mh}, {6'h0, halted, sys_clk_gate});
    chk("watchdog_clear", {7'h0, exp_clr}, {7'h0, watchdog_counter_clr});
    chk("read_data", exp_rd, reg_rdata);
  endtask

  task automatic do_op(input bcdx_pkg::bcdx_op_e o, input logic [7:0] a);
    step(1'b1, o, a, 1'b0, 1'b0, 8'h00, 8'h00);
  endtask

  task automatic do_wr(input logic [7:0] a, input logic [7:0] d);
    step(1'b0, bcdx_pkg::OP_NOP, 8'h00, 1'b1, 1'b0, a, d);
  endtask

  task automatic do_rd(input logic [7:0] a);
    step(1'b0, bcdx_pkg::OP_NOP, 8'h00, 1'b0, 1'b1, a, 8'h00);
  endtask

  // Leave power-down, then make the flags known again
  task automatic wake(input logic [7:0] st);
    do_wr(bcdx_pkg::OFS_CTRL, 8'h01);
    do_wr(bcdx_pkg::OFS_STATUS, {3'h0, st[4:0]});
  endtask

  // Verdict and end of run
  task automatic end_sim();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Hang guard
  initial begin
    #(8 * 5000);
    failures++;
    end_sim();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_b = 1'b0;
    instr = '0;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    foreach (mem[i]) mem[i] = bcdx_pkg::MEM_RST;
    acc = bcdx_pkg::ACC_RST;
    fl = bcdx_pkg::FLAGS_RST;
    {mh, exp_clr, exp_done, p_wr, p_rd, p_addr, p_wd, exp_rd} = '0;
    p_ins = '0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    // Wrap of decrement and increment, back to back on one byte
    do_op(bcdx_pkg::OP_DEC, 8'h03);
    do_op(bcdx_pkg::OP_INC, 8'h03);
    do_op(bcdx_pkg::OP_DECR_ACC, 8'h03);
    do_rd(8'h03);
    do_wr(8'h05, 8'hFF);
    do_op(bcdx_pkg::OP_CPL_ACC, 8'h05);
    do_rd(8'h05);
    // Unmapped offset
    do_wr(8'h1F, 8'hAA);
    do_rd(8'h1F);
    // Wake request while running changes nothing
    do_wr(bcdx_pkg::OFS_CTRL, 8'h01);
    // Decimal adjust over all four corrections
    foreach (adj_tab[i]) begin
      do_wr(bcdx_pkg::OFS_ACC, adj_tab[i][9:2]);
      do_wr(bcdx_pkg::OFS_STATUS, {6'h00, adj_tab[i][1:0]});
      do_op(bcdx_pkg::OP_BCD_ADJ, 8'h07);
      do_rd(8'h07);
    end
    // Halt, refused work, retention, wake
    do_op(bcdx_pkg::OP_HALT, 8'h00);
    do_op(bcdx_pkg::OP_INC, 8'h03);
    do_rd(8'h03);
    do_rd(bcdx_pkg::OFS_ACC);
    // Control write without the wake bit keeps the core halted
    do_wr(bcdx_pkg::OFS_CTRL, 8'h00);
    wake(8'h00);
    // Random traffic
    repeat (300) begin
      r = $random(seed);
      r_a = {4'h0, r[12:9]};
      if (mh && r[1:0] == 2'b00) wake(r[31:24]);
      else if (!mh && r[3:2] == 2'b00) begin
        if (r[8]) do_wr(r_a, r[31:24]);
        else do_wr(r[7] ? bcdx_pkg::OFS_ACC : bcdx_pkg::OFS_STATUS, {3'h0, r[28:24]});
      end else if (!mh && r[3:2] == 2'b01) begin
        r_a = {3'h0, r[14:10]};
        if (r_a == bcdx_pkg::OFS_CTRL) r_a = 8'h13;
        do_rd(r_a);
      end else do_op(bcdx_pkg::bcdx_op_e'(3'h1 + 3'(r[6:4] % 3'h6)), r_a);
    end
    step(1'b0, bcdx_pkg::OP_NOP, 8'h00, 1'b0, 1'b0, 8'h00, 8'h00);
    end_sim();
  end
endmodule
`default_nettype wire

// ==== common/bcdx_pkg.sv ====
`default_nettype none
package bcdx_pkg;
  // ------------------------------------------------------------
  // Register map on the plain software port
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_MEM_BASE = 8'h00; // Data memory bytes start here
  localparam logic [7:0] OFS_ACC = 8'h10; // Accumulator
  localparam logic [7:0] OFS_STATUS = 8'h11; // Status flags
  localparam logic [7:0] OFS_CTRL = 8'h12; // Control, write only
  localparam int unsigned BIT_C = 0; // Carry flag position
  localparam int unsigned BIT_HC = 1; // Half carry flag position
  localparam int unsigned BIT_Z = 2; // Zero flag position
  localparam int unsigned BIT_TMO = 3; // Time-out flag position
  localparam int unsigned BIT_PD = 4; // Power-down flag position
  localparam int unsigned BIT_WAKE = 0; // Control bit that leaves power-down
  // ------------------------------------------------------------
  // Reset values and arithmetic constants
  // ------------------------------------------------------------
  localparam logic [7:0] ACC_RST = 8'h00; // Accumulator after reset
  localparam logic [7:0] MEM_RST = 8'h00; // Memory bytes after reset
  localparam logic [7:0] RDATA_RST = 8'h00; // Read data after reset
  localparam logic [3:0] DIGIT_MAX = 4'h9; // Largest decimal digit
  localparam logic [7:0] ADJ_NONE = 8'h00; // No correction
  localparam logic [7:0] ADJ_LO = 8'h06; // Low digit correction
  localparam logic [7:0] ADJ_HI = 8'h60; // High digit correction
  localparam logic [7:0] ONE = 8'h01; // Step of increment and decrement
  localparam logic [7:0] ZERO = 8'h00; // Zero result
  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NOP = 3'h0,
    OP_CPL_ACC = 3'h1, // complement_to_acc_op
    OP_BCD_ADJ = 3'h2, // decimal_adjust_op
    OP_DEC = 3'h3, // mem_decrement_op
    OP_DECR_ACC = 3'h4, // decrement_to_acc_op
    OP_INC = 3'h5, // Increment memory in place
    OP_HALT = 3'h6 // Enter power-down
  } bcdx_op_e;
  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_HALT = 2'b10
  } bcdx_state_e;
  typedef struct packed {
    logic powerdown_flag;
    logic timeout_flag;
    logic zero_flag;
    logic half_carry_flag;
    logic carry_flag;
  } bcdx_flags_s;
  typedef struct packed {
    logic valid;
    bcdx_op_e op;
    logic [7:0] addr;
  } bcdx_instr_s;
  localparam bcdx_flags_s FLAGS_RST = 5'h00; // All flags clear after reset
endpackage
`default_nettype wire

// ==== hw/bcdx_core.sv ====
`timescale 1ns/1ns
`default_nettype none
module bcdx_core #(
  parameter int unsigned MEM_DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire bcdx_pkg::bcdx_instr_s instr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic [7:0] accumulator,
  output bcdx_pkg::bcdx_flags_s flags,
  output logic halted,
  output logic sys_clk_gate,
  output logic watchdog_counter_clr,
  output logic exec_done
);
  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  localparam int unsigned MAW = (MEM_DEPTH > 1) ? $clog2(MEM_DEPTH) : 1;
  logic [7:0] mem_q [MEM_DEPTH]; // Data memory
  logic [7:0] acc_q; // Accumulator
  bcdx_pkg::bcdx_flags_s flags_q; // Status flags
  bcdx_pkg::bcdx_flags_s flags_d; // Next flags
  bcdx_pkg::bcdx_state_e state_q; // Run or power-down
  bcdx_pkg::bcdx_state_e state_d; // Next state
  logic [7:0] rdata_q; // Read data register
  logic wd_clr_q; // Watchdog clear pulse
  logic done_q; // Instruction retired pulse
  logic gate_q; // System clock gated off

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  wire logic run = (state_q == bcdx_pkg::ST_RUN);
  // Instructions are only taken while running
  wire logic fire = instr.valid && run;
  wire logic [MAW-1:0] idx = instr.addr[MAW-1:0];
  wire logic [7:0] mem_rd = mem_q[idx]; // Addressed byte
  wire logic op_cpl_acc = fire && (instr.op == bcdx_pkg::OP_CPL_ACC);
  wire logic op_bcd_adj = fire && (instr.op == bcdx_pkg::OP_BCD_ADJ);
  wire logic op_dec = fire && (instr.op == bcdx_pkg::OP_DEC);
  wire logic op_decr_acc = fire && (instr.op == bcdx_pkg::OP_DECR_ACC);
  wire logic op_inc = fire && (instr.op == bcdx_pkg::OP_INC);
  wire logic op_halt = fire && (instr.op == bcdx_pkg::OP_HALT);
  // Software port decode
  wire logic bus_mem = ({24'h000000, reg_addr} < MEM_DEPTH);
  wire logic [MAW-1:0] bus_idx = reg_addr[MAW-1:0];
  wire logic wr_acc = reg_wr && (reg_addr == bcdx_pkg::OFS_ACC);
  wire logic wr_stat = reg_wr && (reg_addr == bcdx_pkg::OFS_STATUS);
  wire logic wake = reg_wr && (reg_addr == bcdx_pkg::OFS_CTRL)
                    && reg_wdata[bcdx_pkg::BIT_WAKE] && !run;

  // ------------------------------------------------------------
  // Decimal adjust datapath
  // ------------------------------------------------------------
  // Low digit correction
  wire logic lo_adj = (acc_q[3:0] > bcdx_pkg::DIGIT_MAX)
                      || flags_q.half_carry_flag;
  // High digit correction
  wire logic hi_adj = (acc_q[7:4] > bcdx_pkg::DIGIT_MAX)
                      || flags_q.carry_flag;
  // Pick one of four correction constants
  wire logic [7:0] bcd_corr = (lo_adj ? bcdx_pkg::ADJ_LO : bcdx_pkg::ADJ_NONE)
                              | (hi_adj ? bcdx_pkg::ADJ_HI : bcdx_pkg::ADJ_NONE);
  wire logic [8:0] bcd_sum = {1'b0, acc_q} + {1'b0, bcd_corr};
  // Carry out of the two decimal digits
  wire logic bcd_c = bcd_sum[8] || hi_adj;

  // ------------------------------------------------------------
  // Result selection
  // ------------------------------------------------------------
  wire logic [7:0] res_cpl = ~mem_rd;
  wire logic [7:0] res_dec = mem_rd - bcdx_pkg::ONE;
  wire logic [7:0] res_inc = mem_rd + bcdx_pkg::ONE;
  wire logic acc_ld = op_cpl_acc || op_decr_acc;
  wire logic [7:0] acc_res = op_cpl_acc ? res_cpl : res_dec;
  wire logic mem_ld = op_bcd_adj || op_dec || op_inc;
  wire logic [7:0] mem_res = op_bcd_adj ? bcd_sum[7:0] :
                             (op_dec ? res_dec : res_inc);
  wire logic z_upd = op_cpl_acc || op_dec || op_decr_acc || op_inc;
  wire logic [7:0] z_src = acc_ld ? acc_res : mem_res;
  // Software writes memory only when no instruction writes it
  wire logic bus_mem_wr = reg_wr && bus_mem && !mem_ld;

  // ------------------------------------------------------------
  // Data memory
  // ------------------------------------------------------------
  // Instruction write back wins over a software write
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem_q[i] <= bcdx_pkg::MEM_RST;
      end
    end else if (mem_ld) begin
      mem_q[idx] <= mem_res;
    end else if (bus_mem_wr) begin
      mem_q[bus_idx] <= reg_wdata;
    end
  end

  // ------------------------------------------------------------
  // Accumulator
  // ------------------------------------------------------------
  // Accumulator ops leave memory untouched
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_q <= bcdx_pkg::ACC_RST;
    end else if (acc_ld) begin
      acc_q <= acc_res;
    end else if (wr_acc) begin
      acc_q <= reg_wdata;
    end
  end

  // ------------------------------------------------------------
  // Flags
  // ------------------------------------------------------------
  // Software write first, instruction effects on top
  always_comb begin
    flags_d = flags_q;
    if (wr_stat) begin
      flags_d.carry_flag = reg_wdata[bcdx_pkg::BIT_C];
      flags_d.half_carry_flag = reg_wdata[bcdx_pkg::BIT_HC];
      flags_d.zero_flag = reg_wdata[bcdx_pkg::BIT_Z];
      flags_d.timeout_flag = reg_wdata[bcdx_pkg::BIT_TMO];
      flags_d.powerdown_flag = reg_wdata[bcdx_pkg::BIT_PD];
    end
    if (z_upd) begin
      flags_d.zero_flag = (z_src == bcdx_pkg::ZERO);
    end
    if (op_bcd_adj) begin
      flags_d.carry_flag = bcd_c;
    end
    if (op_halt) begin
      flags_d.powerdown_flag = 1'b1;
      flags_d.timeout_flag = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flags_q <= bcdx_pkg::FLAGS_RST;
    end else begin
      flags_q <= flags_d;
    end
  end

  // ------------------------------------------------------------
  // Run and power-down control
  // ------------------------------------------------------------
  // Halt enters power-down; software wake returns to run
  always_comb begin
    case (state_q)
      bcdx_pkg::ST_RUN: begin
        state_d = op_halt ? bcdx_pkg::ST_HALT : bcdx_pkg::ST_RUN;
      end
      bcdx_pkg::ST_HALT: begin
        state_d = wake ? bcdx_pkg::ST_RUN : bcdx_pkg::ST_HALT;
      end
      default: begin
        state_d = bcdx_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= bcdx_pkg::ST_RUN;
      gate_q <= 1'b0;
      wd_clr_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      gate_q <= (state_d == bcdx_pkg::ST_HALT);
      wd_clr_q <= op_halt;
      done_q <= fire;
    end
  end

  // ------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------
  // Unmapped offsets read as zero
  wire logic [7:0] stat_rd = {3'h0, flags_q.powerdown_flag, flags_q.timeout_flag,
                              flags_q.zero_flag, flags_q.half_carry_flag,
                              flags_q.carry_flag};
  wire logic [7:0] rd_mux = bus_mem ? mem_q[bus_idx] :
                            (reg_addr == bcdx_pkg::OFS_ACC) ? acc_q :
                            (reg_addr == bcdx_pkg::OFS_STATUS) ? stat_rd :
                            bcdx_pkg::RDATA_RST;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= bcdx_pkg::RDATA_RST;
    end else if (reg_rd) begin
      rdata_q <= rd_mux;
    end else begin
      rdata_q <= bcdx_pkg::RDATA_RST;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign reg_rdata = rdata_q;
  assign accumulator = acc_q;
  assign flags = flags_q;
  assign halted = state_q[1]; // One-hot halt bit, straight from the state register
  assign sys_clk_gate = gate_q;
  assign watchdog_counter_clr = wd_clr_q;
  assign exec_done = done_q;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Independent model of the decimal correction
  wire logic [7:0] chk_corr =
    (((acc_q[3:0] > 4'h9) || flags_q.half_carry_flag) ? 8'h06 : 8'h00)
    + (((acc_q[7:4] > 4'h9) || flags_q.carry_flag) ? 8'h60 : 8'h00);

  sequence s_halt_taken;
    op_halt;
  endsequence

  sequence s_halt_effects;
    halted && flags_q.powerdown_flag && !flags_q.timeout_flag;
  endsequence

  a_cpl_to_acc: assert property (
    op_cpl_acc |=> (acc_q == ~$past(mem_rd)) && (mem_q[$past(idx)] == $past(mem_rd))
  ) else $error("complement result or memory wrong");

  a_bcd_lo_adj: assert property (
    (op_bcd_adj && (acc_q[3:0] > 4'h9))
      |=> (mem_q[$past(idx)][3:0] == $past(acc_q[3:0]) + 4'h6)
  ) else $error("low digit not corrected");

  // A valid low digit with no half carry passes through untouched
  a_bcd_lo_keep: assert property (
    (op_bcd_adj && (acc_q[3:0] <= 4'h9) && !flags_q.half_carry_flag)
      |=> (mem_q[$past(idx)][3:0] == $past(acc_q[3:0]))
  ) else $error("low digit changed without cause");

  a_bcd_hi_adj: assert property (
    (op_bcd_adj && flags_q.carry_flag && !lo_adj)
      |=> (mem_q[$past(idx)][7:4] == $past(acc_q[7:4]) + 4'h6)
  ) else $error("high digit not corrected");

  a_bcd_result: assert property (
    op_bcd_adj |=> (mem_q[$past(idx)] == $past(acc_q) + $past(chk_corr))
      && (acc_q == $past(acc_q))
  ) else $error("decimal adjust sum wrong");

  a_bcd_flags: assert property (
    (op_bcd_adj && !wr_stat)
      |=> ($past(flags_q.zero_flag) == flags_q.zero_flag)
      && ($past(flags_q.half_carry_flag) == flags_q.half_carry_flag)
      && (flags_q.carry_flag == ($past(flags_q.carry_flag)
          || ($past({1'b0, acc_q}) + $past({1'b0, chk_corr}) > 9'h0FF)
          || $past(acc_q[7:4] > 4'h9)))
  ) else $error("decimal adjust flags wrong");

  a_dec_in_place: assert property (
    op_dec |=> (mem_q[$past(idx)] == $past(mem_rd) - 8'h01)
  ) else $error("memory decrement wrong");

  a_decr_to_acc: assert property (
    op_decr_acc |=> (acc_q == $past(mem_rd) - 8'h01) && (mem_q[$past(idx)] == $past(mem_rd))
  ) else $error("decrement to accumulator wrong");

  a_inc_in_place: assert property (
    op_inc |=> (mem_q[$past(idx)] == $past(mem_rd) + 8'h01)
  ) else $error("memory increment wrong");

  a_halt_gates: assert property (
    s_halt_taken |=> sys_clk_gate && halted && exec_done
  ) else $error("halt did not gate the clock");

  a_halt_keeps: assert property (
    (halted && !reg_wr) |=> (acc_q == $past(acc_q)) && (flags_q == $past(flags_q))
      && (mem_q[$past(idx)] == $past(mem_rd))
  ) else $error("state lost while halted");

  a_halt_wd_clr: assert property (
    s_halt_taken |=> watchdog_counter_clr ##1 !watchdog_counter_clr
  ) else $error("watchdog clear pulse wrong");

  a_halt_flags: assert property (
    s_halt_taken |=> s_halt_effects
  ) else $error("halt status flags wrong");

  a_zero_flag: assert property (
    (z_upd && !wr_stat) |=> (flags_q.zero_flag == ($past(z_src) == 8'h00))
      && (flags_q.carry_flag == $past(flags_q.carry_flag))
  ) else $error("zero flag wrong");

  // Complement of an all-ones byte must raise the zero flag
  a_cpl_zero: assert property (
    (op_cpl_acc && (mem_rd == 8'hFF)) |=> flags_q.zero_flag
  ) else $error("zero flag missed on complement");

  // Every taken instruction retires exactly one cycle later
  a_done_pulse: assert property (
    fire |=> exec_done
  ) else $error("taken instruction not retired");

  // Requests while powered down are dropped without trace
  a_halt_refuse: assert property (
    (halted && instr.valid) |=> !exec_done && !watchdog_counter_clr
  ) else $error("instruction taken while halted");

  // Power-down holds until software wakes the core
  a_halt_stays: assert property (
    (halted && !wake) |=> halted && sys_clk_gate
  ) else $error("power-down left without wake");

  // Wake resumes execution and lifts the clock gate
  a_wake_runs: assert property (
    wake |=> !halted && !sys_clk_gate
  ) else $error("wake did not resume");

  // Accumulator contents stay readable while powered down
  a_halt_read: assert property (
    (halted && reg_rd && (reg_addr == bcdx_pkg::OFS_ACC)) |=> (reg_rdata == $past(acc_q))
  ) else $error("accumulator lost while halted");
endmodule
`default_nettype wire
